// ==== signal_compare_regs.vh ====
// register map, field layout and reset values of the signal comparator
// included by the comparator module only
`ifndef SIGNAL_COMPARE_REGS_VH
`define SIGNAL_COMPARE_REGS_VH

// register byte offsets
`define CMP_SOURCE_OFS 8'h00
`define CMP_SCALE_OFS 8'h04
`define CMP_REFSEL_OFS 8'h08
`define CMP_STYLE_OFS 8'h0C
`define CMP_TH1_OFS 8'h10
`define CMP_TH2_OFS 8'h14
`define CMP_TH3_OFS 8'h18
`define CMP_TH4_OFS 8'h1C
`define CMP_STATUS_OFS 8'h20

// quantity select codes
`define SRC_FREQUENCY 3'h0
`define SRC_SPEED 3'h1
`define SRC_LOAD 3'h2
`define SRC_CURRENT 3'h3
`define SRC_THERMAL 3'h4
`define SRC_POWER 3'h5

// reference select codes: 0 network, 1..8 presets, 9 selected reference
`define REF_NETWORK 4'h0
`define REF_SELECTED 4'h9

// output style
`define STYLE_WINDOW 1'b0
`define STYLE_BAR 1'b1

// values in tenths: 1000 = 100.0 %
`define PCT_FULL 16'h03E8
`define SCALE_RESET 16'h01F4
`define TH1_RESET 16'h00C8
`define TH2_RESET 16'h0190
`define TH3_RESET 16'h0258
`define TH4_RESET 16'h0320
`define SOURCE_RESET 3'h0
`define REFSEL_RESET 4'h1
`define STYLE_RESET 1'b0

// status field positions
`define STAT_OUT_LSB 0
`define STAT_PCT_LSB 16

`endif

// ==== signal_compare.v ====
// four-threshold drive signal comparator with a classic wishbone register slave
// assumes measurement and reference inputs come from logic on clock_i
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/100ps
`include "signal_compare_regs.vh"

module signal_compare (
  // clock and reset
  input wire clock_i,
  input wire reset_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  // drive quantities, tenths of their units
  input wire [15:0] output_frequency_i,
  input wire [15:0] motor_speed_i,
  input wire [15:0] percent_load_i,
  input wire [15:0] motor_current_i,
  input wire [15:0] thermal_capacity_used_i,
  input wire [15:0] output_power_i,
  // reference sources, tenths of a percent
  input wire [15:0] network_reference_i,
  input wire [127:0] preset_speeds_i,
  input wire [15:0] selected_reference_i,
  // comparator outputs
  output reg [3:0] compare_out_o
);

  reg [2:0] compare_source_r;
  reg [15:0] compare_full_scale_r;
  reg [3:0] compare_reference_select_r;
  reg compare_output_style_r;
  reg [15:0] lowest_threshold_r;
  reg [15:0] second_threshold_r;
  reg [15:0] third_threshold_r;
  reg [15:0] highest_threshold_r;
  reg ack_r;
  reg [15:0] quantity;
  reg [15:0] reference;
  reg [15:0] wr_value;
  reg [3:0] out_nxt;
  reg [31:0] rd_data;
  wire req;
  wire wr_en;
  wire [15:0] wr_low;
  wire [31:0] pct_wide;
  wire [15:0] pct;
  wire [31:0] eff1;
  wire [31:0] eff2;
  wire [31:0] eff3;
  wire [31:0] eff4;
  wire [31:0] pct_scaled;

  // one-wait-state classic cycle
  assign req = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = ack_r;
  assign wr_en = req & wb_we_i & ~ack_r;
  assign wr_low = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00, wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00};

  // clamp written value to 100.0
  always @* begin
    wr_value = (wr_low > `PCT_FULL) ? `PCT_FULL : wr_low;
  end

  // quantity selector
  always @* begin
    case (compare_source_r)
      `SRC_FREQUENCY: quantity = output_frequency_i;
      `SRC_SPEED: quantity = motor_speed_i;
      `SRC_LOAD: quantity = percent_load_i;
      `SRC_CURRENT: quantity = motor_current_i;
      `SRC_THERMAL: quantity = thermal_capacity_used_i;
      `SRC_POWER: quantity = output_power_i;
      default: quantity = 16'h0000;
    endcase
  end

  // reference selector
  always @* begin
    if (compare_reference_select_r == `REF_NETWORK)
      reference = network_reference_i;
    else if (compare_reference_select_r == `REF_SELECTED)
      reference = selected_reference_i;
    else if (compare_reference_select_r < `REF_SELECTED)
      reference = preset_speeds_i[(compare_reference_select_r - 4'h1) * 16 +: 16];
    else
      reference = 16'h0000;
  end

  // normalise to tenths of a percent; zero scale reads as full
  assign pct_wide = (compare_full_scale_r == 16'h0000) ? {16'h0000, `PCT_FULL} :
    ({16'h0000, quantity} * 32'h0000_03E8) / {16'h0000, compare_full_scale_r};
  assign pct = (pct_wide > {16'h0000, `PCT_FULL}) ? `PCT_FULL : pct_wide[15:0];

  // effective thresholds: threshold x reference, both in tenths of a percent
  assign eff1 = lowest_threshold_r * reference;
  assign eff2 = second_threshold_r * reference;
  assign eff3 = third_threshold_r * reference;
  assign eff4 = highest_threshold_r * reference;
  assign pct_scaled = pct * `PCT_FULL;

  // output pattern
  always @* begin
    out_nxt[0] = pct_scaled > eff1;
    out_nxt[1] = pct_scaled > eff2;
    out_nxt[2] = pct_scaled > eff3;
    out_nxt[3] = pct_scaled > eff4;
    if (compare_output_style_r == `STYLE_WINDOW)
      out_nxt[2:0] = out_nxt[2:0] & ~out_nxt[3:1];
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i)
      compare_out_o <= 4'h0;
    else
      compare_out_o <= out_nxt;
  end

  // register writes and ordering enforcement
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ack_r <= 1'b0;
      compare_source_r <= `SOURCE_RESET;
      compare_full_scale_r <= `SCALE_RESET;
      compare_reference_select_r <= `REFSEL_RESET;
      compare_output_style_r <= `STYLE_RESET;
      lowest_threshold_r <= `TH1_RESET;
      second_threshold_r <= `TH2_RESET;
      third_threshold_r <= `TH3_RESET;
      highest_threshold_r <= `TH4_RESET;
    end else begin
      ack_r <= req & ~ack_r;
      if (wr_en) begin
        case (wb_adr_i)
          `CMP_SOURCE_OFS:
            if (wb_sel_i[0] && wb_dat_i[2:0] <= `SRC_POWER)
              compare_source_r <= wb_dat_i[2:0];
          `CMP_SCALE_OFS:
            compare_full_scale_r <= wr_value;
          `CMP_REFSEL_OFS:
            if (wb_sel_i[0] && wb_dat_i[3:0] <= `REF_SELECTED)
              compare_reference_select_r <= wb_dat_i[3:0];
          `CMP_STYLE_OFS:
            if (wb_sel_i[0])
              compare_output_style_r <= wb_dat_i[0];
          // an adjusted threshold pushes its neighbours to keep the order
          `CMP_TH1_OFS: begin
            lowest_threshold_r <= wr_value;
            if (second_threshold_r < wr_value) second_threshold_r <= wr_value;
            if (third_threshold_r < wr_value) third_threshold_r <= wr_value;
            if (highest_threshold_r < wr_value) highest_threshold_r <= wr_value;
          end
          `CMP_TH2_OFS: begin
            second_threshold_r <= wr_value;
            if (lowest_threshold_r > wr_value) lowest_threshold_r <= wr_value;
            if (third_threshold_r < wr_value) third_threshold_r <= wr_value;
            if (highest_threshold_r < wr_value) highest_threshold_r <= wr_value;
          end
          `CMP_TH3_OFS: begin
            third_threshold_r <= wr_value;
            if (lowest_threshold_r > wr_value) lowest_threshold_r <= wr_value;
            if (second_threshold_r > wr_value) second_threshold_r <= wr_value;
            if (highest_threshold_r < wr_value) highest_threshold_r <= wr_value;
          end
          `CMP_TH4_OFS: begin
            highest_threshold_r <= wr_value;
            if (lowest_threshold_r > wr_value) lowest_threshold_r <= wr_value;
            if (second_threshold_r > wr_value) second_threshold_r <= wr_value;
            if (third_threshold_r > wr_value) third_threshold_r <= wr_value;
          end
          default: ;
        endcase
      end
    end
  end

  // read mux
  always @* begin
    case (wb_adr_i)
      `CMP_SOURCE_OFS: rd_data = {29'h0, compare_source_r};
      `CMP_SCALE_OFS: rd_data = {16'h0000, compare_full_scale_r};
      `CMP_REFSEL_OFS: rd_data = {28'h0, compare_reference_select_r};
      `CMP_STYLE_OFS: rd_data = {31'h0, compare_output_style_r};
      `CMP_TH1_OFS: rd_data = {16'h0000, lowest_threshold_r};
      `CMP_TH2_OFS: rd_data = {16'h0000, second_threshold_r};
      `CMP_TH3_OFS: rd_data = {16'h0000, third_threshold_r};
      `CMP_TH4_OFS: rd_data = {16'h0000, highest_threshold_r};
      `CMP_STATUS_OFS: rd_data = {pct, 12'h000, compare_out_o};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i)
      wb_dat_o <= 32'h0000_0000;
    else if (req & ~ack_r)
      wb_dat_o <= rd_data;
  end

endmodule // signal_compare

// ==== drive_sources.sv ====
// drive quantity and speed reference model
// assumes the comparator samples on clock_i
`timescale 1ns/100ps
module drive_sources (
  // clock and base level
  input wire clock_i,
  input wire [15:0] level_i,
  // quantities and references, tenths
  output reg [95:0] quantities_o,
  output reg [15:0] network_o,
  output reg [127:0] presets_o,
  output reg [15:0] selected_o
);
  integer k;
  always @(posedge clock_i) begin
    for (k = 0; k < 6; k = k + 1)
      quantities_o[16*k +: 16] <= level_i + 16'h0064 * k[15:0];
    for (k = 0; k < 8; k = k + 1)
      presets_o[16*k +: 16] <= 16'h0064 * (k[15:0] + 16'h0001);
    network_o <= 16'h03E8;
    selected_o <= 16'h012C;
  end
endmodule // drive_sources

// ==== signal_compare_sva.sv ====
// port assertions for the comparator
// bound into every signal_compare
`timescale 1ns/100ps
module signal_compare_chk (
  // watched ports
  input wire clock_i,
  input wire reset_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [3:0] compare_out_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire rd_w = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  a_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_out_pattern: assert property ($onehot0(compare_out_o) || compare_out_o inside {4'h3, 4'h7, 4'hF})
    else $error("bad output pattern");
  a_unmapped_zero: assert property (rd_w && wb_adr_i > 8'h20 |=> wb_dat_o == 32'h00000000) else $error("unmapped data");
  a_pct_clamp: assert property (rd_w && wb_adr_i == 8'h20 |=> wb_dat_o[31:16] <= 16'h03E8)
    else $error("percent too big");
  a_setting_clamp: assert property (rd_w && wb_adr_i inside {8'h04, 8'h10, 8'h14, 8'h18, 8'h1C}
    |=> wb_dat_o[15:0] <= 16'h03E8) else $error("setting too big");
  a_source_range: assert property (rd_w && wb_adr_i == 8'h00 |=> wb_dat_o[2:0] <= 3'h5)
    else $error("bad source");
  a_refsel_range: assert property (rd_w && wb_adr_i == 8'h08 |=> wb_dat_o[3:0] <= 4'h9)
    else $error("bad reference select");
endmodule // signal_compare_chk
bind signal_compare signal_compare_chk u_chk (.clock_i, .reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .compare_out_o);

// ==== tb_top.sv ====
// bench for the signal comparator
// drives wishbone and a drive source model
`timescale 1ns/100ps
module tb_top;
  reg clock_i = 1'b0;
  reg reset_i = 1'b1;
  reg cyc = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] dat = 32'h00000000;
  reg [15:0] level = 16'h0064;
  reg [31:0] got;
  wire [31:0] rdat;
  wire ack;
  wire [3:0] cmp;
  wire [95:0] q;
  wire [15:0] net_ref, sel_ref;
  wire [127:0] presets;
  integer bad_count = 0, checked = 0, s, r, st, p;
  always #5 clock_i = ~clock_i;
  drive_sources u_drive_sources (.clock_i, .level_i(level), .quantities_o(q), .network_o(net_ref),
    .presets_o(presets), .selected_o(sel_ref));
  signal_compare u_signal_compare (.clock_i, .reset_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .output_frequency_i(q[15:0]), .motor_speed_i(q[31:16]), .percent_load_i(q[47:32]),
    .motor_current_i(q[63:48]), .thermal_capacity_used_i(q[79:64]), .output_power_i(q[95:80]),
    .network_reference_i(net_ref), .preset_speeds_i(presets), .selected_reference_i(sel_ref),
    .compare_out_o(cmp));
  task final_report;
    begin
      if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task bus(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
      adr <= a; we <= w; dat <= d; cyc <= 1'b1;
      n = 0;
      @(posedge clock_i);
      while (ack !== 1'b1 && n < 50) begin
        @(posedge clock_i);
        n = n + 1;
      end
      got = rdat;
      if (n == 50) begin
        bad_count = bad_count + 1;
        final_report;
      end
      cyc <= 1'b0; we <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      bus(a, 1'b0, 32'h00000000);
      chk(got, e);
    end
  endtask
  function [3:0] exp_out(input integer p, input integer r, input integer st);
    reg [3:0] b;
    begin
      b = {p * 1000 > 800 * r, p * 1000 > 700 * r, p * 1000 > 700 * r, p * 1000 > 200 * r};
      exp_out = st ? b : b & ~(b >> 1);
    end
  endfunction
  initial begin
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(8'h04, 32'h000001F4);
    rd(8'h10, 32'h000000C8);
    bus(8'h14, 1'b1, 32'h000002BC);
    rd(8'h18, 32'h000002BC);
    for (s = 0; s < 6; s = s + 1) begin
      bus(8'h00, 1'b1, s);
      p = (100 + 100 * s) * 2;
      if (p > 1000) p = 1000;
      for (r = 0; r < 3; r = r + 1) begin
        bus(8'h08, 1'b1, r * 4 + (r > 0));
        for (st = 0; st < 2; st = st + 1) begin
          bus(8'h0C, 1'b1, st);
          repeat (3) @(posedge clock_i);
          chk({28'h0000000, cmp}, {28'h0000000, exp_out(p, r == 0 ? 1000 : r == 1 ? 500 : 300, st)});
        end
      end
    end
    rd(8'h20, 32'h03E8000F);
    bus(8'h00, 1'b1, 32'h00000007);
    rd(8'h00, 32'h00000005);
    bus(8'h08, 1'b1, 32'h0000000A);
    rd(8'h08, 32'h00000009);
    bus(8'h10, 1'b1, 32'h00000FFF);
    rd(8'h1C, 32'h000003E8);
    bus(8'h24, 1'b1, 32'h00000001);
    rd(8'h24, 32'h00000000);
    final_report;
  end
endmodule // tb_top
